// File: logic/jtr_tap_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module jtr_tap_ctrl
(
	input  wire logic               clk,
	input  wire logic               rstn,
	input  wire logic               tck,
	input  wire logic               tms,
	input  wire logic               tdi,
	input  wire logic               testResetN,
	output var  logic               tdo,
	output var  logic               tdoEn,
	output var  logic               testEnable,
	output var  jtr_pkg::jtr_status_t status
);

	// ==========================================================
	// Pin synchronisers
	// ==========================================================
	logic tckSync;
	logic tmsSync;
	logic tdiSync;
	logic tckPrev;

	jtr_pin_sync
	#(
		.RESET_VAL (jtr_pkg::TCK_IDLE)
	)
	uTck
	(
		.clk      (clk),
		.rstn     (rstn),
		.pinIn    (tck),
		.pinSync  (tckSync)
	);

	jtr_pin_sync
	#(
		.RESET_VAL (jtr_pkg::TMS_IDLE)
	)
	uTms
	(
		.clk      (clk),
		.rstn     (rstn),
		.pinIn    (tms),
		.pinSync  (tmsSync)
	);

	jtr_pin_sync
	#(
		.RESET_VAL (jtr_pkg::TDI_IDLE)
	)
	uTdi
	(
		.clk      (clk),
		.rstn     (rstn),
		.pinIn    (tdi),
		.pinSync  (tdiSync)
	);

	// The test reset acts with no clock at all, so it is combined
	// straight into the asynchronous reset; the release is then
	// synchronised so no flop leaves reset on a ragged edge.
	logic trRaw;
	logic trMeta;
	logic trRel;
	assign trRaw = rstn & testResetN;

	// Release synchroniser for the combined reset.
	always_ff @(posedge clk or negedge trRaw)
	begin
		if (!trRaw)
		begin
			trMeta <= 1'b0;
			trRel  <= 1'b0;
		end
		else
		begin
			trMeta <= 1'b1;
			trRel  <= trMeta;
		end
	end

	// A test reset also clears the controller at once, independently
	// of the release stage, so reset is never missed.
	logic tapRstn;
	assign tapRstn = trRel & testResetN;

	// ==========================================================
	// Edge detect of the sampled test clock
	// ==========================================================
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			tckPrev <= jtr_pkg::TCK_IDLE;
		else
			tckPrev <= tckSync;
	end

	logic tckRise;
	logic tckFall;
	assign tckRise = tckSync & ~tckPrev;
	assign tckFall = ~tckSync & tckPrev;

	// ==========================================================
	// Controller state machine
	// ==========================================================
	jtr_pkg::jtr_state_t state;
	jtr_pkg::jtr_state_t next_state;

	// Next state from tms; five tms-high edges reach reset from
	// anywhere because each high step moves closer to it.
	always_comb
	begin
		next_state = state;
		unique case (state)
			jtr_pkg::TestLogicReset:
				next_state = tmsSync ? jtr_pkg::TestLogicReset
				                     : jtr_pkg::RunTestIdle;
			jtr_pkg::RunTestIdle:
				next_state = tmsSync ? jtr_pkg::SelectDr
				                     : jtr_pkg::RunTestIdle;
			jtr_pkg::SelectDr:
				next_state = tmsSync ? jtr_pkg::SelectIr
				                     : jtr_pkg::CaptureDr;
			jtr_pkg::CaptureDr:
				next_state = tmsSync ? jtr_pkg::Exit1Dr
				                     : jtr_pkg::ShiftDr;
			jtr_pkg::ShiftDr:
				next_state = tmsSync ? jtr_pkg::Exit1Dr
				                     : jtr_pkg::ShiftDr;
			jtr_pkg::Exit1Dr:
				next_state = tmsSync ? jtr_pkg::UpdateDr
				                     : jtr_pkg::PauseDr;
			jtr_pkg::PauseDr:
				next_state = tmsSync ? jtr_pkg::Exit2Dr
				                     : jtr_pkg::PauseDr;
			jtr_pkg::Exit2Dr:
				next_state = tmsSync ? jtr_pkg::UpdateDr
				                     : jtr_pkg::ShiftDr;
			jtr_pkg::UpdateDr:
				next_state = tmsSync ? jtr_pkg::SelectDr
				                     : jtr_pkg::RunTestIdle;
			jtr_pkg::SelectIr:
				next_state = tmsSync ? jtr_pkg::TestLogicReset
				                     : jtr_pkg::CaptureIr;
			jtr_pkg::CaptureIr:
				next_state = tmsSync ? jtr_pkg::Exit1Ir
				                     : jtr_pkg::ShiftIr;
			jtr_pkg::ShiftIr:
				next_state = tmsSync ? jtr_pkg::Exit1Ir
				                     : jtr_pkg::ShiftIr;
			jtr_pkg::Exit1Ir:
				next_state = tmsSync ? jtr_pkg::UpdateIr
				                     : jtr_pkg::PauseIr;
			jtr_pkg::PauseIr:
				next_state = tmsSync ? jtr_pkg::Exit2Ir
				                     : jtr_pkg::PauseIr;
			jtr_pkg::Exit2Ir:
				next_state = tmsSync ? jtr_pkg::UpdateIr
				                     : jtr_pkg::ShiftIr;
			jtr_pkg::UpdateIr:
				next_state = tmsSync ? jtr_pkg::SelectDr
				                     : jtr_pkg::RunTestIdle;
		endcase
	end

	// State advances on sampled rising tck; reset is asynchronous.
	always_ff @(posedge clk or negedge tapRstn)
	begin
		if (!tapRstn)
			state <= jtr_pkg::TestLogicReset;
		else if (tckRise)
			state <= next_state;
	end

	// ==========================================================
	// Instruction and bypass registers
	// ==========================================================
	logic [jtr_pkg::IR_WIDTH-1:0] irShift;
	logic [jtr_pkg::IR_WIDTH-1:0] instr;
	logic                         bypassBit;

	logic inReset;
	assign inReset = (state == jtr_pkg::TestLogicReset);

	// Shift stage; capture loads the fixed pattern.
	always_ff @(posedge clk or negedge tapRstn)
	begin
		if (!tapRstn)
			irShift <= jtr_pkg::IR_BYPASS;
		else if (tckRise && state == jtr_pkg::CaptureIr)
			irShift <= jtr_pkg::IR_CAPTURE;
		else if (tckRise && state == jtr_pkg::ShiftIr)
			irShift <= {tdiSync, irShift[jtr_pkg::IR_WIDTH-1:1]};
	end

	// Output latches update on the falling edge in Update-IR and are
	// forced to bypass whenever the controller sits in reset, so a
	// synchronous reset through tms also clears the instruction.
	always_ff @(posedge clk or negedge tapRstn)
	begin
		if (!tapRstn)
			instr <= jtr_pkg::IR_BYPASS;
		else if (inReset)
			instr <= jtr_pkg::IR_BYPASS;
		else if (tckFall && state == jtr_pkg::UpdateIr)
			instr <= irShift;
	end

	// Single-bit bypass path.
	always_ff @(posedge clk or negedge tapRstn)
	begin
		if (!tapRstn)
			bypassBit <= 1'b0;
		else if (tckRise && state == jtr_pkg::ShiftDr)
			bypassBit <= tdiSync;
	end

	// ==========================================================
	// Serial output, driven on falling tck while shifting
	// ==========================================================
	logic shifting;
	assign shifting = (state == jtr_pkg::ShiftIr)
	                | (state == jtr_pkg::ShiftDr);

	always_ff @(posedge clk or negedge tapRstn)
	begin
		if (!tapRstn)
		begin
			tdo   <= 1'b0;
			tdoEn <= 1'b0;
		end
		else if (tckFall)
		begin
			tdo   <= (state == jtr_pkg::ShiftIr) ? irShift[0] : bypassBit;
			tdoEn <= shifting;
		end
	end

	// ==========================================================
	// Status towards the device core
	// ==========================================================
	// Test logic stays off in reset so the core runs unaffected.
	always_ff @(posedge clk or negedge tapRstn)
	begin
		if (!tapRstn)
		begin
			testEnable <= 1'b0;
			status     <= '0;
		end
		else
		begin
			testEnable        <= ~inReset;
			status.instr      <= instr;
			status.state      <= state;
			status.testEnable <= ~inReset;
		end
	end

endmodule
`default_nettype wire

// File: logic/jtr_pkg.sv
// Function
// - Low test reset holds controller in reset.
// - Reset entry loads bypass instruction.
// - In reset, test logic off, device normal.
// - Leave reset only via tms after release.
// - Test reset acts asynchronously, no tck needed.
// - Five tms-high tck edges force reset.
`default_nettype none
package jtr_pkg;

	// ==========================================================
	// Controller states and instruction encoding
	// ==========================================================
	typedef enum logic [3:0]
	{
		TestLogicReset, RunTestIdle, SelectDr, CaptureDr, ShiftDr,
		Exit1Dr, PauseDr, Exit2Dr, UpdateDr, SelectIr, CaptureIr,
		ShiftIr, Exit1Ir, PauseIr, Exit2Ir, UpdateIr
	} jtr_state_t;

	localparam int IR_WIDTH = 4;
	localparam logic [IR_WIDTH-1:0] IR_BYPASS = 4'hf;
	localparam logic [IR_WIDTH-1:0] IR_CAPTURE = 4'h1;
	localparam int SYNC_STAGES = 2;

	// Pin levels assumed while the synchronisers are in reset. The
	// edge detector starts from the same test clock level, so no
	// false edge follows reset.
	localparam logic TCK_IDLE = 1'b0;
	localparam logic TMS_IDLE = 1'b1;
	localparam logic TDI_IDLE = 1'b1;

	// Status bundle presented to the surrounding device.
	typedef struct packed
	{
		logic [IR_WIDTH-1:0] instr;
		logic [3:0]          state;
		logic                testEnable;
	} jtr_status_t;

endpackage
`default_nettype wire

// File: logic/jtr_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
// Two-flop synchroniser; the first stage feeds only the second.
module jtr_pin_sync
#(
	parameter logic RESET_VAL = 1'b1
)
(
	input  wire logic clk,
	input  wire logic rstn,
	input  wire logic pinIn,
	output var  logic pinSync
);

	logic stage1;

	// ==========================================================
	// Sampling
	// ==========================================================
	// Reset value is a parameter so the reset branch stays constant;
	// it should match the pin's idle level to avoid a false edge.
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			stage1  <= RESET_VAL;
			pinSync <= RESET_VAL;
		end
		else
		begin
			stage1  <= pinIn;
			pinSync <= stage1;
		end
	end

endmodule
`default_nettype wire

// File: tb/jtr_tap_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ======
// Pin checker.
module jtr_tap_chk
(
	input wire logic                 clk,
	input wire logic                 rstn,
	input wire logic                 tck,
	input wire logic                 tms,
	input wire logic                 tdi,
	input wire logic                 testResetN,
	input wire logic                 tdo,
	input wire logic                 tdoEn,
	input wire logic                 testEnable,
	input wire jtr_pkg::jtr_status_t status
);
	logic       prevTck;
	logic [2:0] highCnt;
	wire        tckRise = tck && !prevTck;
	// Counts tms-high rises; sticks at five so one rise fires once.
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			prevTck <= 1'b0;
			highCnt <= 3'h0;
		end
		else
		begin
			prevTck <= tck;
			if (!testResetN || (tckRise && !tms))
				highCnt <= 3'h0;
			else if (tckRise && highCnt != 3'h5)
				highCnt <= highCnt + 3'h1;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	sequence riseLow;
		tckRise && !tms && testResetN;
	endsequence
	sequence riseHigh;
		tckRise && tms && testResetN;
	endsequence
	AST_TRST_HOLD: assert property (!testResetN |->
		!testEnable && status.state == 4'h0) else $error("Left reset.");
	AST_TRST_QUIET: assert property (!testResetN |->
		!tdoEn && !tdo) else $error("Drives tdo in reset.");
	AST_TLR_BYPASS: assert property (
		(testResetN && status.state == 4'h0)[*6] |-> status.instr == 4'hf)
		else $error("No bypass code.");
	AST_TLR_NO_TEST: assert property (status.state == 4'h0 |->
		!status.testEnable) else $error("Test on in reset.");
	AST_STAY_RESET: assert property (
		(!testEnable && $stable(tck))[*8] |=> !testEnable)
		else $error("Left reset without tck.");
	AST_FIVE_HIGH: assert property ($rose(highCnt == 3'h5) |->
		##[0:8] status.state == 4'h0) else $error("Five highs missed.");
	AST_TLR_TO_IDLE: assert property (status.state == 4'h0 ##0 riseLow
		|-> ##[3:8] status.state == 4'h1) else $error("No idle.");
	AST_IDLE_TO_SEL: assert property (status.state == 4'h1 ##0 riseHigh
		|-> ##[3:8] status.state == 4'h2) else $error("No select.");
endmodule
bind jtr_tap_ctrl jtr_tap_chk i_chk (.clk(clk), .rstn(rstn), .tck(tck),
	.tms(tms), .tdi(tdi), .testResetN(testResetN), .tdo(tdo),
	.tdoEn(tdoEn), .testEnable(testEnable), .status(status));
`default_nettype wire

// File: tb/jtr_tester.sv
`timescale 1ns/1ps
`default_nettype none
// ======
// Boundary-scan tester; tck stands still between steps.
module jtr_tester
(
	input  wire logic clk,
	output var  logic tck,
	output var  logic tms,
	output var  logic tdi,
	output var  logic testResetN
);
	// Starts in test reset with tms at its pull-up level.
	initial
	begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b1;
		testResetN = 1'b0;
	end
	// One 170 ns tck period; tms then returns high and tdi goes to an unlike level.
	task automatic step(input logic m, input logic d);
		@(negedge clk);
		tms = m;
		tdi = d;
		repeat (8) @(negedge clk);
		tck = 1'b1;
		repeat (8) @(negedge clk);
		tck = 1'b0;
		tms = 1'b1;
		tdi = ~d;
	endtask
	// Raising tms first avoids the unsupported tms-low reset pair.
	task automatic setTrst(input logic v);
		@(negedge clk);
		tms = 1'b1;
		testResetN = v;
	endtask
endmodule
`default_nettype wire

// File: tb/jtr_tap_reset_init_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin fail_count++; \
	$display("[ERR] %0t got %h want %h", $time, a, b); end end
// ======
// Bench for the test port controller.
module jtr_tap_reset_init_bench;
	logic clk, rstn, tck, tms, tdi, testResetN, tdo, tdoEn, testEnable;
	jtr_pkg::jtr_status_t status;
	int                   fail_count = 0;
	int                   checks_done = 0;
	jtr_tap_ctrl i_dut (.clk(clk), .rstn(rstn), .tck(tck), .tms(tms),
		.tdi(tdi), .testResetN(testResetN), .tdo(tdo), .tdoEn(tdoEn),
		.testEnable(testEnable), .status(status));
	jtr_tester i_tst (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi),
		.testResetN(testResetN));
	// Free-running 100 MHz clock.
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Gives the synchronisers time to show the last tck edge.
	task settle;
		repeat (6) @(negedge clk);
	endtask
	task seq(input logic [7:0] m, input logic [7:0] d, input int n);
		for (int i = 0; i < n; i++)
			i_tst.step(m[i], d[i]);
		settle;
	endtask
	task report_and_stop;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task t_walk;
		`CHK(testEnable, 1'b0)
		i_tst.setTrst(1'b1);
		settle;
		`CHK(testEnable, 1'b0)
		seq(8'h03, 8'h00, 2);
		`CHK(status.state, 4'h0)
		seq(8'h00, 8'h00, 1);
		`CHK(status.state, 4'h1)
		`CHK(testEnable, 1'b1)
		`CHK(status.instr, 4'hf)
		$display("walk done");
	endtask
	task t_ir;
		seq(8'h03, 8'h00, 4);
		`CHK(status.state, jtr_pkg::ShiftIr)
		`CHK({tdoEn, tdo}, 2'h3)
		seq(8'h18, 8'h03, 6);
		`CHK(status.instr, 4'h3)
		$display("ir done");
	endtask
	task t_five;
		seq(8'h01, 8'h00, 3);
		`CHK(tdoEn, 1'b1)
		seq(8'h0f, 8'h00, 4);
		`CHK(status.state, jtr_pkg::SelectIr)
		seq(8'h01, 8'h00, 1);
		`CHK(status.state, 4'h0)
		`CHK({testEnable, tdoEn}, 2'h0)
		`CHK(status.instr, 4'hf)
		$display("five done");
	endtask
	task t_async;
		seq(8'h02, 8'h00, 4);
		i_tst.setTrst(1'b0);
		@(negedge clk);
		`CHK({testEnable, tdoEn, status.state}, 6'h0)
		seq(8'h01, 8'h00, 1);
		`CHK(status.state, 4'h0)
		i_tst.setTrst(1'b1);
		settle;
		seq(8'h00, 8'h00, 1);
		`CHK(status.state, 4'h1)
		$display("async done");
	endtask
	// Main sequence.
	initial
	begin
		rstn = 1'b0;
		repeat (10) @(negedge clk);
		rstn = 1'b1;
		t_walk;
		t_ir;
		t_five;
		t_async;
		report_and_stop;
	end
	// Watchdog: the tests need about 5.5 us.
	initial
	begin
		#100000;
		fail_count++;
		report_and_stop;
	end
endmodule
`default_nettype wire
